// ==== pkg/adcr_pkg.sv ====
// Function
// - Single-shot start command launches one conversion; mid-conversion it resets filter, restarts.
// - Continuous mode: one start begins conversions; further starts reset filter and restart.
// - Sleep command powers down analog and both current sources, keeping registers.
// - Sleep during a conversion waits for that conversion to finish first.
// - Start command while asleep restores the analog state held before sleep.
// - Read-result command copies latest completed result into the output shift register.
// - Result fetch is a write frame with the command, then a read frame.
// - Result finishing during the command byte: old result loaded keeps ready set; here only when it lands in the cycle the byte is acted on.
// - Register-read command in write frame; following read frame returns that register.
// - Register-write is address plus data byte; several may chain in one frame.
// - Each register write resets the filter and restarts a running conversion.
// - Ready status bit is set whenever a new result is available.
// - Results finishing mid-transfer never disturb bytes already being shifted out.
// - Counter enabled: counter byte advances with every new result.
// - Selected integrity words follow the result or register data directly.
// - CRC16 option always appends exactly two bytes.
// - Inverted mode appends three inverted result bytes, four with the counter enabled, one after register data.
// - Four 8-bit registers, zero after reset, kept through power-down.
// - Register fields sit at the fixed positions of the register map.
// - Command bytes are latched and acted on at their eighth falling clock edge.
// - Ready pin goes low on a new result, high once it is latched.
// - Reset command returns to defaults with no wait before further traffic.
// - Results are 24-bit two's complement.
package adcr_pkg;
    // Command byte decode, upper seven or four bits
    localparam logic [6:0] CMD7_SLEEP = 7'h01;
    localparam logic [6:0] CMD7_RESET = 7'h03;
    localparam logic [6:0] CMD7_START = 7'h04;
    localparam logic [3:0] CMD4_RDATA = 4'h1;
    localparam logic [3:0] CMD4_REG_READ_CMD = 4'h2;
    localparam logic [3:0] CMD4_REG_WRITE_CMD = 4'h4;
    // Register offsets and reset value
    localparam logic [1:0] REG_INPUT_GAIN = 2'h0;
    localparam logic [1:0] REG_RATE_MODE_REF = 2'h1;
    localparam logic [1:0] REG_STATUS_INTEG = 2'h2;
    localparam logic [1:0] REG_CURRENT_ROUTE = 2'h3;
    localparam logic [7:0] REG_RESET = 8'h00;
    // Field positions and write masks
    localparam int CONV_MODE_BIT = 3;
    localparam int READY_BIT = 7;
    localparam int COUNTER_EN_BIT = 6;
    localparam int INTEG_LSB = 4;
    localparam int IDAC_LSB = 0;
    localparam logic [7:0] STATUS_WMASK = 8'h7f;
    localparam logic [7:0] ROUTE_WMASK = 8'hfc;
    // Integrity selection codes
    localparam logic [1:0] INTEG_NONE = 2'h0;
    localparam logic [1:0] INTEG_INV = 2'h1;
    localparam logic [1:0] INTEG_CRC = 2'h2;
    localparam logic [15:0] CRC_POLY = 16'h1021;
    localparam logic [15:0] CRC_INIT = 16'hffff;
    // Serial byte framing
    localparam logic [3:0] ACK_SLOT = 4'h8;
    localparam int RESULT_BITS = 24;
    localparam int TX_BITS = 64;

    typedef enum logic [1:0] {
        CS_CMD = 2'b01,
        CS_WDATA = 2'b10
    } adcr_cmd_t;

    typedef enum logic [2:0] {
        PW_ON = 3'b001,
        PW_PEND = 3'b010,
        PW_OFF = 3'b100
    } adcr_pwr_t;
endpackage

// ==== rtl/adcr_engine.sv ====
module adcr_engine
    import adcr_pkg::*;
(
    // Clock, reset, enable
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic ce,
    // Serial clock and data pins
    input wire logic scl_pin,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Frame events from the address stage, same clock
    input wire logic frame_start,
    input wire logic frame_read,
    input wire logic frame_stop,
    // Ready pin, open drain, active low
    output logic result_ready_n_out,
    output logic result_ready_n_oe,
    // Converter core
    input wire logic conv_done,
    input wire logic [RESULT_BITS-1:0] conv_data,
    input wire logic conv_busy,
    output logic conv_start,
    output logic filter_reset,
    output logic conv_continuous,
    output logic analog_on,
    output logic idac_on,
    // Configuration registers
    output logic [7:0] cfg_input_gain,
    output logic [7:0] cfg_rate_mode_ref,
    output logic [7:0] cfg_status_integ,
    output logic [7:0] cfg_current_route
);

    // CRC over the first n bytes of a left-aligned word
    function automatic logic [15:0] crc16(input logic [31:0] d, input logic [2:0] n);
        logic [15:0] c;
        logic fb;
        c = CRC_INIT;
        fb = 1'b0;
        for (int i = 0; i < 32; i++)
        begin
            if (i < 8 * int'(n))
            begin
                fb = c[15] ^ d[31-i];
                c = {c[14:0], 1'b0};
                if (fb)
                begin
                    c = c ^ CRC_POLY;
                end
            end
        end
        return c;
    endfunction

    logic scl_s1, scl_s2, scl_d;
    logic sda_s1, sda_s2;
    logic [7:0] rx_sh, next_rx_sh;
    logic [3:0] bit_cnt, next_bit_cnt;
    logic in_frame, next_in_frame;
    logic rd_frame, next_rd_frame;
    adcr_cmd_t cmd_st, next_cmd_st;
    logic [1:0] wr_addr, next_wr_addr;
    logic [TX_BITS-1:0] tx_buf, next_tx_buf;
    logic oe_q, next_oe_q;
    logic [7:0] cfg [4];
    logic [7:0] next_cfg [4];
    logic ready_bit, next_ready_bit;
    logic [7:0] conv_cnt, next_conv_cnt;
    logic [RESULT_BITS-1:0] result, next_result;
    adcr_pwr_t pw_st, next_pw_st;
    logic start_q, next_start_q;
    logic freset_q, next_freset_q;

    logic scl_rise, scl_fall;
    logic [7:0] status_rd;

    // Pin synchronisers; the first stage feeds only the second
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            scl_s1 <= 1'b1;
            scl_s2 <= 1'b1;
            scl_d <= 1'b1;
            sda_s1 <= 1'b1;
            sda_s2 <= 1'b1;
        end
        else if (ce)
        begin
            scl_s1 <= scl_pin;
            scl_s2 <= scl_s1;
            scl_d <= scl_s2;
            sda_s1 <= sda_in;
            sda_s2 <= sda_s1;
        end
    end

    assign scl_rise = scl_s2 & ~scl_d;
    assign scl_fall = ~scl_s2 & scl_d;
    // Ready bit lives outside the stored byte so it cannot be written
    assign status_rd = {ready_bit, cfg[REG_STATUS_INTEG][6:0]};

    // Next-state logic for link, commands, registers and power
    always_comb
    begin
        logic [7:0] cmd;
        logic [31:0] pay;
        logic [31:0] pmask;
        logic [2:0] nby;
        logic [5:0] sh;
        logic load_tx;
        logic [1:0] integ;
        cmd = rx_sh;
        pay = 32'h0;
        pmask = 32'h0;
        nby = 3'h0;
        sh = 6'h0;
        load_tx = 1'b0;
        integ = cfg[REG_STATUS_INTEG][INTEG_LSB +: 2];
        next_rx_sh = rx_sh;
        next_bit_cnt = bit_cnt;
        next_in_frame = in_frame;
        next_rd_frame = rd_frame;
        next_cmd_st = cmd_st;
        next_wr_addr = wr_addr;
        next_tx_buf = tx_buf;
        next_oe_q = oe_q;
        next_cfg = cfg;
        next_ready_bit = ready_bit;
        next_conv_cnt = conv_cnt;
        next_result = result;
        next_pw_st = pw_st;
        next_start_q = 1'b0;
        next_freset_q = 1'b0;

        // Sleep waits for the running conversion to end
        if (pw_st == PW_PEND && !conv_busy)
        begin
            next_pw_st = PW_OFF;
        end

        // Frame boundaries
        if (frame_start)
        begin
            next_in_frame = 1'b1;
            next_rd_frame = frame_read;
            next_bit_cnt = 4'h0;
            next_oe_q = 1'b0;
            next_cmd_st = CS_CMD;
            if (frame_read)
            begin
                // First bit goes out before the first rising edge
                next_oe_q = ~tx_buf[TX_BITS-1];
                next_tx_buf = {tx_buf[TX_BITS-2:0], 1'b1};
            end
        end
        else if (frame_stop)
        begin
            next_in_frame = 1'b0;
            next_rd_frame = 1'b0;
            next_oe_q = 1'b0;
            next_cmd_st = CS_CMD;
        end
        else if (in_frame && scl_rise)
        begin
            next_bit_cnt = (bit_cnt == ACK_SLOT) ? 4'h0 : bit_cnt + 4'h1;
            if (!rd_frame && bit_cnt != ACK_SLOT)
            begin
                next_rx_sh = {rx_sh[6:0], sda_s2};
            end
        end
        else if (in_frame && scl_fall && rd_frame)
        begin
            // Host acknowledges in slot nine; shift fills with ones
            if (bit_cnt == ACK_SLOT)
            begin
                next_oe_q = 1'b0;
            end
            else
            begin
                next_oe_q = ~tx_buf[TX_BITS-1];
                next_tx_buf = {tx_buf[TX_BITS-2:0], 1'b1};
            end
        end
        else if (in_frame && scl_fall && bit_cnt == ACK_SLOT)
        begin
            // Eighth falling edge: acknowledge and act on the byte
            next_oe_q = 1'b1;
            unique case (cmd_st)
                CS_WDATA:
                begin
                    next_cmd_st = CS_CMD;
                    unique case (wr_addr)
                        REG_STATUS_INTEG: next_cfg[wr_addr] = cmd & STATUS_WMASK;
                        REG_CURRENT_ROUTE: next_cfg[wr_addr] = cmd & ROUTE_WMASK;
                        default: next_cfg[wr_addr] = cmd;
                    endcase
                    next_freset_q = 1'b1;
                    next_start_q = conv_busy;
                end
                CS_CMD:
                begin
                    if (cmd[7:1] == CMD7_START)
                    begin
                        next_freset_q = 1'b1;
                        next_start_q = 1'b1;
                        next_pw_st = PW_ON;
                    end
                    else if (cmd[7:1] == CMD7_SLEEP)
                    begin
                        next_pw_st = conv_busy ? PW_PEND : PW_OFF;
                    end
                    else if (cmd[7:1] == CMD7_RESET)
                    begin
                        for (int i = 0; i < 4; i++)
                        begin
                            next_cfg[i] = REG_RESET;
                        end
                        next_ready_bit = 1'b0;
                        next_conv_cnt = 8'h00;
                        next_pw_st = PW_ON;
                        next_freset_q = 1'b1;
                    end
                    else if (cmd[7:4] == CMD4_RDATA)
                    begin
                        load_tx = 1'b1;
                        next_ready_bit = 1'b0;
                        if (cfg[REG_STATUS_INTEG][COUNTER_EN_BIT])
                        begin
                            pay = {conv_cnt, result};
                            nby = 3'h4;
                        end
                        else
                        begin
                            pay = {result, 8'h00};
                            nby = 3'h3;
                        end
                    end
                    else if (cmd[7:4] == CMD4_REG_READ_CMD)
                    begin
                        load_tx = 1'b1;
                        nby = 3'h1;
                        unique case (cmd[3:2])
                            REG_STATUS_INTEG: pay = {status_rd, 24'h0};
                            default: pay = {cfg[cmd[3:2]], 24'h0};
                        endcase
                    end
                    else if (cmd[7:4] == CMD4_REG_WRITE_CMD)
                    begin
                        next_wr_addr = cmd[3:2];
                        next_cmd_st = CS_WDATA;
                    end
                end
            endcase
        end
        else if (in_frame && scl_fall && bit_cnt == 4'h0)
        begin
            // Release the acknowledge after slot nine
            next_oe_q = 1'b0;
        end

        // Build the readout: payload, then integrity words
        if (load_tx)
        begin
            sh = {nby, 3'b000};
            pmask = ~(32'hffffffff >> sh);
            next_tx_buf = {pay, 32'hffffffff} | ~({pmask, 32'h0});
            if (integ == INTEG_INV)
            begin
                next_tx_buf = {pay, 32'h0} | ({~pay & pmask, 32'h0} >> sh);
                next_tx_buf = next_tx_buf | ~({pmask, 32'h0} | ({pmask, 32'h0} >> sh));
            end
            else if (integ == INTEG_CRC)
            begin
                next_tx_buf = {pay, 32'h0} | ({crc16(pay, nby), 48'h0} >> sh);
                next_tx_buf = next_tx_buf
                    | ~({pmask, 32'h0} | ({16'hffff, 48'h0} >> sh));
            end
        end

        // New results; a set in the same cycle beats the clear
        if (conv_done)
        begin
            next_result = conv_data;
            next_conv_cnt = next_conv_cnt + 8'h01;
            next_ready_bit = 1'b1;
        end
    end

    // State registers, frozen while the enable is low
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rx_sh <= 8'h00;
            bit_cnt <= 4'h0;
            in_frame <= 1'b0;
            rd_frame <= 1'b0;
            cmd_st <= CS_CMD;
            wr_addr <= 2'h0;
            tx_buf <= '1;
            oe_q <= 1'b0;
            for (int i = 0; i < 4; i++)
            begin
                cfg[i] <= REG_RESET;
            end
            ready_bit <= 1'b0;
            conv_cnt <= 8'h00;
            result <= '0;
            pw_st <= PW_ON;
            start_q <= 1'b0;
            freset_q <= 1'b0;
        end
        else if (ce)
        begin
            rx_sh <= next_rx_sh;
            bit_cnt <= next_bit_cnt;
            in_frame <= next_in_frame;
            rd_frame <= next_rd_frame;
            cmd_st <= next_cmd_st;
            wr_addr <= next_wr_addr;
            tx_buf <= next_tx_buf;
            oe_q <= next_oe_q;
            cfg <= next_cfg;
            ready_bit <= next_ready_bit;
            conv_cnt <= next_conv_cnt;
            result <= next_result;
            pw_st <= next_pw_st;
            start_q <= next_start_q;
            freset_q <= next_freset_q;
        end
    end

    // Open-drain pins only ever pull low
    assign sda_out = 1'b0;
    assign sda_oe = oe_q;
    assign result_ready_n_out = 1'b0;
    assign result_ready_n_oe = ready_bit;

    // Converter control; registers survive power-down untouched
    assign conv_start = start_q;
    assign filter_reset = freset_q;
    assign conv_continuous = cfg[REG_RATE_MODE_REF][CONV_MODE_BIT];
    assign analog_on = (pw_st != PW_OFF);
    assign idac_on = (pw_st != PW_OFF) && (cfg[REG_STATUS_INTEG][IDAC_LSB +: 3] != 3'h0);

    assign cfg_input_gain = cfg[REG_INPUT_GAIN];
    assign cfg_rate_mode_ref = cfg[REG_RATE_MODE_REF];
    assign cfg_status_integ = status_rd;
    assign cfg_current_route = cfg[REG_CURRENT_ROUTE];
endmodule

// ==== testbench/adcr_engine_bench.sv ====
module adcr_engine_bench;
    import adcr_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk, sys_rst, ce, scl_pin, sda_in, sda_oe, frame_start, frame_read, frame_stop;
    logic result_ready_n_oe, conv_done, conv_busy, conv_start, filter_reset, conv_continuous;
    logic analog_on, idac_on, rx_valid, ack_n, sda_out, result_ready_n_out;
    logic [7:0] cfg_input_gain, cfg_rate_mode_ref, cfg_status_integ, cfg_current_route, rx_byte;
    logic [23:0] conv_data, v, w;
    logic [15:0] c;
    logic [7:0] d[4];
    logic [7:0] q[$];
    int miscompares = 0, total_checks = 0, seed = 32'hd3dc, n_fr = 0, n_cs = 0;
    adcr_engine u_dut (.*);
    adcr_host u_host (.*);
    initial
    begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    // Pulse counters for filter clears and restarts
    always @(posedge core_clk)
    begin
        n_fr += filter_reset;
        n_cs += conv_start;
    end
    task automatic chk(input logic [7:0] g, e);
        total_checks++;
        if (g !== e)
        begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // Every received byte is matched against the oldest note
    always @(posedge rx_valid)
        chk(rx_byte, q.size() ? q.pop_front() : 8'hxx);
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic wr(input logic [7:0] b);
        u_host.byte_out(b);
        chk(ack_n, 1'b0);
    endtask
    task automatic cmd(input logic [7:0] b);
        u_host.frame_begin(1'b0);
        wr(b);
        u_host.frame_end();
    endtask
    task automatic reg_write_cmd(input logic [1:0] a, input logic [7:0] b);
        u_host.frame_begin(1'b0);
        wr({4'h4, a, 2'h0});
        wr(b);
        u_host.frame_end();
    endtask
    task automatic rd(input int n);
        u_host.frame_begin(1'b1);
        for (int i = 1; i <= n; i++)
            u_host.byte_in(i == n);
        u_host.frame_end();
    endtask
    task automatic fetch(input int n);
        cmd(8'h10);
        rd(n);
    endtask
    task automatic push3(input logic [23:0] x);
        q.push_back(x[23:16]);
        q.push_back(x[15:8]);
        q.push_back(x[7:0]);
    endtask
    task automatic done(input logic [23:0] x);
        conv_data = x;
        conv_done = 1'b1;
        @(negedge core_clk);
        conv_done = 1'b0;
        repeat (2) @(negedge core_clk);
    endtask
    // Reference CRC over counter and result, most significant bit first
    function automatic logic [15:0] crc(input logic [31:0] x);
        logic [15:0] r;
        r = CRC_INIT;
        for (int i = 31; i >= 0; i--)
            r = {r[14:0], 1'b0} ^ ((r[15] ^ x[i]) ? CRC_POLY : 16'h0000);
        return r;
    endfunction
    // Hang guard
    initial
    begin
        repeat (100000) @(posedge core_clk);
        miscompares++;
        summarize();
    end
    initial
    begin
        {sys_rst, ce, conv_done, conv_busy} = 4'h c;
        conv_data = 24'h000000;
        repeat (2) @(negedge core_clk);
        sys_rst = 1'b0;
        repeat (4) @(negedge core_clk);
        chk(cfg_input_gain | cfg_rate_mode_ref | cfg_status_integ | cfg_current_route, 8'h00);
        chk(analog_on, 1'b1);
        // All four registers in one chained frame, integrity off
        u_host.frame_begin(1'b0);
        for (int a = 0; a < 4; a++)
        begin
            d[a] = 8'($random(seed));
            if (a == 2)
                d[a] = {4'h0, d[a][3:1], 1'b1};
            wr({4'h4, a[1:0], 2'h0});
            wr(d[a]);
        end
        u_host.frame_end();
        d[3][1:0] = 2'h0;
        chk(8'(n_fr), 8'h04);
        chk(8'(n_cs), 8'h00);
        chk(conv_continuous, d[1][3]);
        chk(cfg_current_route, d[3]);
        for (int a = 0; a < 4; a++)
        begin
            q.push_back(d[a]);
            cmd({4'h2, a[1:0], 2'h0});
            rd(1);
        end
        // Start, busy register write, then sleep held off by the busy conversion
        cmd(8'h08);
        conv_busy = 1'b1;
        reg_write_cmd(2'h0, d[0]);
        chk(8'(n_cs), 8'h02);
        cmd(8'h02);
        chk(analog_on, 1'b1);
        conv_busy = 1'b0;
        for (int i = 0; i < 8 && analog_on; i++)
            @(negedge core_clk);
        chk(analog_on | idac_on, 1'b0);
        chk(cfg_input_gain, d[0]);
        cmd(8'h08);
        chk(idac_on, 1'b1);
        // Result flagged, fetched, flag cleared
        v = 24'($random(seed));
        done(v);
        chk(result_ready_n_oe & cfg_status_integ[7], 1'b1);
        chk(result_ready_n_oe ? result_ready_n_out : 1'b1, 1'b0);
        push3(v);
        fetch(3);
        chk(result_ready_n_oe, 1'b0);
        // Enable low: a result offered then is never taken
        w = 24'($random(seed));
        ce = 1'b0;
        done(w);
        ce = 1'b1;
        chk(result_ready_n_oe, 1'b0);
        // Slow host; a result lands in mid-readout
        u_host.slow = 3;
        push3(v);
        cmd(8'h10);
        fork
            rd(3);
            begin
                repeat (20) @(negedge core_clk);
                done(w);
            end
        join
        push3(w);
        fetch(3);
        u_host.slow = 0;
        // Reset command, then counter with inverted copies, then CRC
        cmd(8'h06);
        chk(cfg_status_integ | cfg_input_gain, 8'h00);
        chk(8'(n_fr), 8'h08);
        reg_write_cmd(2'h2, 8'h50);
        done(v);
        q.push_back(8'h01);
        push3(v);
        q.push_back(8'hfe);
        push3(~v);
        fetch(8);
        reg_write_cmd(2'h2, 8'h60);
        done(w);
        c = crc({8'h02, w});
        q.push_back(8'h02);
        push3(w);
        q.push_back(c[15:8]);
        q.push_back(c[7:0]);
        // Past the readout the line idles high
        q.push_back(8'hff);
        fetch(7);
        chk(8'(q.size()), 8'h00);
        summarize();
    end
endmodule

// ==== testbench/adcr_engine_properties.sv ====
module adcr_engine_properties
    import adcr_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic ce,
    // Serial pins
    input wire logic scl_pin,
    input wire logic sda_oe,
    // Converter core
    input wire logic conv_done,
    input wire logic conv_busy,
    input wire logic conv_start,
    input wire logic filter_reset,
    input wire logic analog_on,
    input wire logic idac_on,
    // Ready pin and registers
    input wire logic result_ready_n_oe,
    input wire logic [7:0] cfg_input_gain,
    input wire logic [7:0] cfg_rate_mode_ref,
    input wire logic [7:0] cfg_status_integ,
    input wire logic [7:0] cfg_current_route
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);
    // New result, then pin and status bit both raised
    sequence s_done;
        conv_done && ce;
    endsequence
    sequence s_flagged;
        ##1 result_ready_n_oe && cfg_status_integ[READY_BIT];
    endsequence
    a_done_sets_ready: assert property (s_done |-> s_flagged)
        else $error("ready not raised after a result");
    a_ready_pin_bit: assert property (result_ready_n_oe == cfg_status_integ[READY_BIT])
        else $error("ready pin and status bit disagree");
    a_route_low_zero: assert property (cfg_current_route[1:0] == 2'h0)
        else $error("routing register low bits not zero");
    // Power-down only once the running conversion has ended
    a_sleep_waits: assert property ($fell(analog_on) |-> !$past(conv_busy))
        else $error("powered down during a conversion");
    a_sleep_keeps_regs: assert property ($fell(analog_on) |->
        $stable(cfg_input_gain) && $stable(cfg_rate_mode_ref) && $stable(cfg_current_route))
        else $error("register changed on power-down");
    // One cycle of grace in case the source gate is registered
    a_idac_off_sleep: assert property (!analog_on [*2] |-> !idac_on)
        else $error("current source on while powered down");
    a_start_resets: assert property (conv_start |-> filter_reset)
        else $error("restart without filter clear");
    a_pulse_single: assert property (filter_reset |=> !filter_reset)
        else $error("filter clear longer than one cycle");
    a_sda_scl_low: assert property ($changed(sda_oe) |-> !scl_pin)
        else $error("data line moved while clock high");
endmodule

bind adcr_engine adcr_engine_properties u_props (.*);

// ==== testbench/adcr_host.sv ====
module adcr_host (
    // Clock and device drive
    input wire logic core_clk,
    input wire logic sda_oe,
    input wire logic sda_out,
    // Bus pins toward the device
    output logic scl_pin,
    output logic sda_in,
    // Frame events
    output logic frame_start,
    output logic frame_read,
    output logic frame_stop,
    // Received bytes and last acknowledge
    output logic rx_valid,
    output logic [7:0] rx_byte,
    output logic ack_n
);
    timeunit 1ns;
    timeprecision 1ps;
    int slow = 0;
    logic sda_drv = 1'b1;
    // Pulled-up wire, low if either side pulls
    assign sda_in = sda_drv & ~(sda_oe & ~sda_out);
    initial
    begin
        scl_pin = 1'b1;
        {frame_start, frame_read, frame_stop, rx_valid, ack_n} = 5'h00;
        rx_byte = 8'h00;
    end
    task automatic wt(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    // Data moves only with the clock low; slow stretches that phase
    task automatic pulse(input logic b, output logic s);
        wt(2 + slow);
        sda_drv = b;
        wt(2);
        scl_pin = 1'b1;
        wt(3);
        s = sda_in;
        wt(1);
        scl_pin = 1'b0;
    endtask
    // Clock parked low before the frame is announced
    task automatic frame_begin(input logic rd);
        scl_pin = 1'b0;
        wt(5);
        frame_read = rd;
        frame_start = 1'b1;
        wt(1);
        frame_start = 1'b0;
    endtask
    task automatic byte_out(input logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--)
            pulse(b[i], s);
        pulse(1'b1, ack_n);
    endtask
    // Last byte is refused; the device ignores the acknowledge and keeps shifting until the stop
    task automatic byte_in(input logic last);
        logic [7:0] r;
        logic s;
        for (int i = 7; i >= 0; i--)
        begin
            pulse(1'b1, s);
            r[i] = s;
        end
        pulse(last, s);
        rx_byte = r;
        rx_valid = 1'b1;
        wt(1);
        rx_valid = 1'b0;
    endtask
    // Stop leaves the clock high and still until the next frame
    task automatic frame_end();
        sda_drv = 1'b0;
        // Device lets go of its acknowledge about three cycles after the fall
        wt(4);
        scl_pin = 1'b1;
        wt(2);
        sda_drv = 1'b1;
        frame_stop = 1'b1;
        wt(1);
        frame_stop = 1'b0;
        wt(4);
    endtask
endmodule
